// ---- edge_detect.sv ----
// Rising and falling edge detector for a pclk-synchronous input
`timescale 1ns/1ns
`default_nettype none
module edge_detect
   import timer_pkg::*;
(
   input  wire logic    pclk,
   input  wire logic    presetn,
   input  wire logic    clear,
   input  wire logic    level,
   output var  edges_s  edges
);
   logic prev_q;

   // Clear keeps a stale level from faking an edge on wake-up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= 1'b0;
      end else if (clear) begin
         prev_q <= level;
      end else begin
         prev_q <= level;
      end
   end

   always_comb begin
      edges.rise = level & ~prev_q & ~clear;
      edges.fall = ~level & prev_q & ~clear;
   end
endmodule : edge_detect
`default_nettype wire

// ---- far_side_model.sv ----
// Far-side model: count input, low-power clock and trigger sources
`timescale 1ns/1ns
`default_nettype none
module far_side_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       fall_run,
   input  wire logic       lp_run,
   input  wire logic [7:0] trig_lvl,
   output logic            count_input,
   output logic            low_power_clock,
   output logic [7:0]      trigger_in
);
   // ---------------------------------------------------------------
   // Sources
   // ---------------------------------------------------------------
   // Idle levels: count line high, clock still low between bursts
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_input     <= 1'b1;
         low_power_clock <= 1'b0;
         trigger_in      <= 8'h00;
      end else begin
         if (fall_run)
            count_input <= ~count_input;
         if (lp_run)
            low_power_clock <= ~low_power_clock;
         trigger_in <= trig_lvl;
      end
   end
endmodule : far_side_model
`default_nettype wire

// ---- multimode_up_timer.sv ----
// Multimode up-counting timer/counter with an APB register slave
//
// Behaviour
// - Count only upward over a 16-bit value built from two byte counters.
// - Six modes; clock source selectable between fast and low-power clock.
// - Timer operation steps once per prescaled period of the chosen clock.
// - Counter operation steps on each falling edge of the count input.
// - Prescaler divides the chosen clock by one, two, four or eight.
// - Undivided fast clock lets the count advance every pclk.
// - Counting starts from the loaded count and runs to a mode maximum; in trigger mode a trigger starts it from zero.
// - Separate low-byte and high-byte overflow interrupt sources.
// - Software low and high run bits start and stop counting.
// - Trigger mode adds hardware run control from on-chip trigger inputs.
// - 16-bit compare value raises the overflow flag on equality in trigger mode; reload and measure use its low byte.
// - Module disable bit set stops the whole timer.
// - Overflow sets its flag; interrupt only when its enable bit is set.
// - Split mode: low run bit drives low byte, high run bit high byte.
// - Power-down bit resets the timer and gates its clocking.
`timescale 1ns/1ns
`default_nettype none
`include "timer_consts.svh"
module multimode_up_timer
   import timer_pkg::*;
#(
   parameter int TRIG_WIDTH = 8
)(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  low_power_clock,
   input  wire logic                  slow_reference_clock,
   input  wire logic                  count_input,
   input  wire logic [TRIG_WIDTH-1:0] trigger_in,
   output logic                       irq
);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   ctrl_s                   ctrl_q;
   clkcfg_s                 clkcfg_q;
   trig_s                   trig_q;
   logic [7:0]              lo_q;
   logic [7:0]              hi_q;
   logic [7:0]              lo_d;
   logic [7:0]              hi_d;
   logic [15:0]             cmp_q;
   logic [15:0]             cmp_shadow_q;
   logic [`STS_WIDTH-1:0]   status_q;
   logic [`STS_WIDTH-1:0]   mask_q;
   logic [`PWR_WIDTH-1:0]   pwr_q;
   logic [2:0]              presc_q;
   logic                    active_q;
   logic [31:0]             prdata_q;
   logic                    pready_q;
   logic                    pslverr_q;
   logic                    irq_q;

   mode_e                   mode;
   logic                    bus_access;
   logic                    bus_wr;
   logic                    mapped;
   logic [31:0]             rd_value;
   logic                    halted;
   logic                    powered_down;
   logic                    src_tick;
   logic                    presc_tick;
   logic                    tick;
   logic [2:0]              presc_last;
   logic                    run_lo;
   logic                    run_hi;
   logic                    set_lo;
   logic                    set_hi;
   logic                    trig_event;
   logic                    trig_level;
   logic                    stop_active;
   logic [4:0]              lo5_inc;
   edges_s                  lp_edges;
   edges_s                  cnt_edges;
   edges_s                  ref_edges;
   edges_s                  trig_edges;

   // ---------------------------------------------------------------
   // Mode decode
   // ---------------------------------------------------------------
   always_comb begin
      unique case ({ctrl_q.main_mode, ctrl_q.sub_mode})
         4'b0000: mode = MODE_13BIT;
         4'b0100: mode = MODE_16BIT;
         4'b0101: mode = MODE_TRIG;
         4'b1000: mode = MODE_RELOAD;
         4'b1100: mode = MODE_SPLIT;
         4'b1110: mode = MODE_MEASURE;
         // Undefined codes fall back to the plain 16-bit counter
         default: mode = MODE_16BIT;
      endcase
   end

   assign halted       = pwr_q[`PWR_DISABLE] | pwr_q[`PWR_DOWN];
   assign powered_down = pwr_q[`PWR_DOWN];

   // ---------------------------------------------------------------
   // Input edges
   // ---------------------------------------------------------------
   assign trig_level = trigger_in[trig_q.source_sel];

   edge_detect u_lp_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .clear   (halted),
      .level   (low_power_clock),
      .edges   (lp_edges)
   );

   edge_detect u_cnt_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .clear   (halted),
      .level   (count_input),
      .edges   (cnt_edges)
   );

   edge_detect u_ref_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .clear   (halted),
      .level   (slow_reference_clock),
      .edges   (ref_edges)
   );

   edge_detect u_trig_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .clear   (halted),
      .level   (trig_level),
      .edges   (trig_edges)
   );

   // ---------------------------------------------------------------
   // Clock source and prescaler
   // ---------------------------------------------------------------
   // Fast module clock is pclk itself, so its source tick is constant
   assign src_tick   = clkcfg_q.low_power_sel ? lp_edges.rise : 1'b1;
   assign presc_last = 3'((4'h1 << clkcfg_q.div) - 4'h1);
   assign presc_tick = src_tick & (presc_q == presc_last);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_q <= 3'h0;
      end else if (halted) begin
         presc_q <= 3'h0;
      end else if (src_tick) begin
         presc_q <= (presc_q == presc_last) ? 3'h0 : 3'(presc_q + 3'h1);
      end
   end

   // Count input edges bypass the prescaler
   assign tick = ~halted & (ctrl_q.count_mode ? cnt_edges.fall
                                              : presc_tick);

   // ---------------------------------------------------------------
   // Trigger control
   // ---------------------------------------------------------------
   assign trig_event = (mode == MODE_TRIG) & ctrl_q.low_run_bit &
                       ((trig_q.edge_sel[0] & trig_edges.rise) |
                        (trig_q.edge_sel[1] & trig_edges.fall));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_q     <= 1'b0;
         cmp_shadow_q <= `RST_CMP;
      end else if (halted) begin
         active_q     <= 1'b0;
      end else if (trig_event) begin
         active_q     <= 1'b1;
         // Compare is taken on the trigger so edits act next period
         cmp_shadow_q <= cmp_q;
      end else if (stop_active) begin
         active_q     <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Count next state
   // ---------------------------------------------------------------
   always_comb begin
      lo_d        = lo_q;
      hi_d        = hi_q;
      set_lo      = 1'b0;
      set_hi      = 1'b0;
      stop_active = 1'b0;
      run_lo      = ctrl_q.low_run_bit;
      run_hi      = ctrl_q.high_run_bit;
      lo5_inc     = 5'(lo_q[4:0] + 5'h01);
      unique case (mode)
         MODE_13BIT: begin
            if (run_lo && tick) begin
               lo_d[4:0] = lo5_inc;
               if (lo_q[4:0] == `LOW5_MAX) begin
                  set_lo = 1'b1;
                  hi_d   = 8'(hi_q + 8'h01);
                  set_hi = (hi_q == `BYTE_MAX);
               end
            end
         end
         MODE_16BIT: begin
            if (run_lo && tick) begin
               lo_d = 8'(lo_q + 8'h01);
               if (lo_q == `BYTE_MAX) begin
                  set_lo = 1'b1;
                  hi_d   = 8'(hi_q + 8'h01);
                  set_hi = (hi_q == `BYTE_MAX);
               end
            end
         end
         MODE_TRIG: begin
            if (trig_event) begin
               lo_d = `RST_CNT;
               hi_d = `RST_CNT;
            end else if (active_q && run_lo && tick) begin
               {hi_d, lo_d} = 16'({hi_q, lo_q} + 16'h0001);
               if ({hi_q, lo_q} == 16'hffff) begin
                  set_lo      = 1'b1;
                  stop_active = 1'b1;
               end else if (16'({hi_q, lo_q} + 16'h0001) == cmp_shadow_q) begin
                  set_lo      = 1'b1;
                  stop_active = 1'b1;
               end
            end
         end
         MODE_RELOAD: begin
            if (run_lo && tick) begin
               if (lo_q == `BYTE_MAX) begin
                  lo_d   = hi_q;
                  set_lo = 1'b1;
               end else begin
                  lo_d   = 8'(lo_q + 8'h01);
                  set_lo = (8'(lo_q + 8'h01) == cmp_q[7:0]);
               end
            end
         end
         MODE_SPLIT: begin
            if (run_lo && tick) begin
               lo_d   = 8'(lo_q + 8'h01);
               set_lo = (lo_q == `BYTE_MAX);
            end
            if (run_hi && tick) begin
               hi_d   = 8'(hi_q + 8'h01);
               set_hi = (hi_q == `BYTE_MAX);
            end
         end
         MODE_MEASURE: begin
            // Low byte counts reference edges, high byte the time between
            if (run_lo && ~halted && ref_edges.rise) begin
               lo_d   = 8'(lo_q + 8'h01);
               set_lo = (lo_q == `BYTE_MAX) |
                        (8'(lo_q + 8'h01) == cmp_q[7:0]);
            end
            if (run_hi && tick) begin
               hi_d   = 8'(hi_q + 8'h01);
               set_hi = (hi_q == `BYTE_MAX);
            end
         end
      endcase
   end

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   // One wait-free access phase: pready rises for the access cycle
   assign bus_access = psel & penable & pready_q;
   assign bus_wr     = bus_access & pwrite;

   always_comb begin
      mapped   = 1'b1;
      rd_value = 32'h0000_0000;
      unique case (paddr)
         `OFS_CTRL:   rd_value[`CTRL_WIDTH-1:0] = ctrl_q;
         `OFS_CNT_LO: rd_value[7:0]             = lo_q;
         `OFS_CNT_HI: rd_value[7:0]             = hi_q;
         `OFS_CMP:    rd_value[15:0]            = cmp_q;
         `OFS_STATUS: rd_value[`STS_WIDTH-1:0]  = status_q;
         `OFS_MASK:   rd_value[`STS_WIDTH-1:0]  = mask_q;
         `OFS_PWR:    rd_value[`PWR_WIDTH-1:0]  = pwr_q;
         `OFS_CLKCFG: rd_value[`CLK_WIDTH-1:0]  = clkcfg_q;
         `OFS_TRIG:   rd_value[`TRIG_WIDTH-1:0] = trig_q;
         default:     mapped                    = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= psel & ~penable & ~pready_q;
         pslverr_q <= psel & ~penable & ~pready_q & ~mapped;
         if (psel && !penable && !pwrite) begin
            prdata_q <= rd_value;
         end
      end
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q   <= `RST_CTRL;
         cmp_q    <= `RST_CMP;
         mask_q   <= `RST_MASK;
         pwr_q    <= `RST_PWR;
         clkcfg_q <= `RST_CLKCFG;
         trig_q   <= `RST_TRIG;
      end else if (bus_wr) begin
         unique case (paddr)
            `OFS_CTRL:   ctrl_q   <= pwdata[`CTRL_WIDTH-1:0];
            `OFS_CMP:    cmp_q    <= pwdata[15:0];
            `OFS_MASK:   mask_q   <= pwdata[`STS_WIDTH-1:0];
            `OFS_PWR:    pwr_q    <= pwdata[`PWR_WIDTH-1:0];
            `OFS_CLKCFG: clkcfg_q <= pwdata[`CLK_WIDTH-1:0];
            `OFS_TRIG:   trig_q   <= pwdata[`TRIG_WIDTH-1:0];
            default: begin
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Count registers
   // ---------------------------------------------------------------
   // Software writes take priority over a hardware step
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lo_q <= `RST_CNT;
         hi_q <= `RST_CNT;
      end else if (powered_down) begin
         lo_q <= `RST_CNT;
         hi_q <= `RST_CNT;
      end else begin
         lo_q <= (bus_wr && paddr == `OFS_CNT_LO) ? pwdata[7:0] : lo_d;
         hi_q <= (bus_wr && paddr == `OFS_CNT_HI) ? pwdata[7:0] : hi_d;
      end
   end

   // ---------------------------------------------------------------
   // Overflow flags and interrupt
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= `RST_STATUS;
      end else begin
         for (int i = 0; i < `STS_WIDTH; i++) begin
            if ((i == `STS_LOW_OVF && set_lo) ||
                (i == `STS_HIGH_OVF && set_hi)) begin
               status_q[i] <= 1'b1;
            end else if (bus_wr && paddr == `OFS_STATUS && pwdata[i]) begin
               status_q[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & mask_q);
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign irq     = irq_q;

endmodule : multimode_up_timer
`default_nettype wire

// ---- multimode_up_timer_asserts.sv ----
// Port-level checker for the multimode up timer
`timescale 1ns/1ns
`default_nettype none
`include "timer_consts.svh"
module multimode_up_timer_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq
);
   // ---------------------------------------------------------------
   // Helper state and properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [15:0] cmp_q;
   wire  logic  acc;
   assign acc = psel && penable && pready;
   // Shadow of the compare word, to judge read-back
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_q <= 16'h0000;
      end else if (acc && pwrite && paddr == `OFS_CMP) begin
         cmp_q <= pwdata[15:0];
      end
   end
   property p_ready_after_setup;
      psel && !penable |=> pready;
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup)
      else $error("pready missing in access cycle");
   property p_ready_single;
      pready |=> !pready;
   endproperty
   a_ready_single: assert property (p_ready_single)
      else $error("pready held longer than one cycle");
   property p_err_with_ready;
      pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready)
      else $error("pslverr without pready");
   property p_unmapped_read;
      psel && !penable && !pwrite && paddr[11:6] != 6'h00
         |=> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped read not refused");
   property p_cmp_readback;
      acc && !pwrite && paddr == `OFS_CMP |-> prdata == {16'h0, cmp_q};
   endproperty
   a_cmp_readback: assert property (p_cmp_readback)
      else $error("compare word read-back differs");
   property p_upper_zero;
      acc && !pwrite |-> prdata[31:16] == 16'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("read data above bit 15 not zero");
   property p_mask_quiets_irq;
      acc && pwrite && paddr == `OFS_MASK && pwdata[1:0] == 2'b00
         |-> ##2 !irq;
   endproperty
   a_mask_quiets_irq: assert property (p_mask_quiets_irq)
      else $error("irq high with all sources masked");
   property p_irq_sticky;
      irq && !$past(acc && pwrite) |=> irq;
   endproperty
   a_irq_sticky: assert property (p_irq_sticky)
      else $error("irq dropped without a register write");
endmodule : multimode_up_timer_asserts
bind multimode_up_timer multimode_up_timer_asserts u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .irq(irq)
);
`default_nettype wire

// ---- multimode_up_timer_test.sv ----
// Self-checking testbench of the multimode up timer
`timescale 1ns/1ns
`default_nettype none
`include "timer_consts.svh"
module multimode_up_timer_test;
   // ---------------------------------------------------------------
   // Signals, instances and tasks
   // ---------------------------------------------------------------
   logic        pclk, presetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, irq, rd_err, fall_run, lp_run;
   logic        count_input, low_power_clock;
   logic [7:0]  trigger_in, trig_lvl;
   logic [15:0] c;
   int          failures, compares;
   multimode_up_timer #(.TRIG_WIDTH(8)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .low_power_clock(low_power_clock),
      .slow_reference_clock(low_power_clock),
      .count_input(count_input), .trigger_in(trigger_in), .irq(irq)
   );
   far_side_model far (
      .pclk(pclk), .presetn(presetn), .fall_run(fall_run), .lp_run(lp_run),
      .trig_lvl(trig_lvl), .count_input(count_input),
      .low_power_clock(low_power_clock), .trigger_in(trigger_in)
   );
   task automatic finish_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : finish_test
   task automatic chk(input string nm, input logic [31:0] e, x);
      compares++;
      if (x !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, x);
      end
   endtask : chk
   // Entered just after a rising edge; leaves one idle cycle behind
   task automatic apb(input logic w, input logic [11:0] a, input int d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         failures++;
         finish_test;
      end
      rd = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [11:0] a, input int d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdchk(input logic [11:0] a, input int e, string nm);
      apb(1'b0, a, 0);
      chk(nm, e, rd);
   endtask : rdchk
   task automatic rdcnt;
      apb(1'b0, `OFS_CNT_LO, 0);
      c[7:0] = rd[7:0];
      apb(1'b0, `OFS_CNT_HI, 0);
      c[15:8] = rd[7:0];
   endtask : rdcnt
   task automatic t_reset;
      rdchk(`OFS_CTRL, 0, "ctrl");
      rdchk(`OFS_CMP, 0, "compare");
      rdchk(`OFS_STATUS, 0, "status");
      rdchk(`OFS_PWR, 0, "power");
      apb(1'b0, 12'h100, 0);
      chk("unmapped error", 1, {31'h0, rd_err});
      chk("unmapped data", 0, rd);
      $display("done reset test");
   endtask : t_reset
   task automatic t_rate;
      logic [15:0] e;
      for (int d = 0; d < 4; d++) begin
         wr(`OFS_CNT_LO, 0);
         wr(`OFS_CNT_HI, 0);
         wr(`OFS_CLKCFG, d << 1);
         wr(`OFS_CTRL, 32'h09);
         repeat (64) @(posedge pclk);
         wr(`OFS_CTRL, 32'h08);
         rdcnt;
         e = 16'(66 >> d);
         compares++;
         if (c < e - 16'd2 || c > e + 16'd2) begin
            failures++;
            $display("wrong value rate count expected %h seen %h", e, c);
         end
      end
      $display("done rate test");
   endtask : t_rate
   // Sixteen source toggles give eight falls or eight rises
   task automatic t_burst(input int ctrl, input logic lp,
                          input logic [15:0] pre, input int e);
      wr(`OFS_CNT_LO, pre[7:0]);
      wr(`OFS_CNT_HI, pre[15:8]);
      wr(`OFS_CLKCFG, {31'h0, lp});
      wr(`OFS_CTRL, ctrl);
      fall_run <= !lp;
      lp_run <= lp;
      repeat (16) @(posedge pclk);
      fall_run <= 1'b0;
      lp_run <= 1'b0;
      repeat (4) @(posedge pclk);
      rdcnt;
      chk("burst count", e, {16'h0, c});
      wr(`OFS_CTRL, 0);
      $display("done burst test");
   endtask : t_burst
   task automatic t_power;
      wr(`OFS_CNT_LO, 32'h10);
      wr(`OFS_CNT_HI, 0);
      wr(`OFS_CLKCFG, 0);
      wr(`OFS_PWR, 1);
      wr(`OFS_CTRL, 32'h09);
      repeat (20) @(posedge pclk);
      rdcnt;
      chk("count disabled", 32'h10, {16'h0, c});
      wr(`OFS_PWR, 2);
      rdcnt;
      chk("count powered down", 0, {16'h0, c});
      wr(`OFS_PWR, 0);
      wr(`OFS_CTRL, 0);
      $display("done power test");
   endtask : t_power
   task automatic t_irq;
      int n;
      wr(`OFS_STATUS, 3);
      wr(`OFS_MASK, 0);
      wr(`OFS_CNT_LO, 32'hf0);
      wr(`OFS_CNT_HI, 0);
      wr(`OFS_CTRL, 32'h09);
      repeat (40) @(posedge pclk);
      wr(`OFS_CTRL, 32'h08);
      rdchk(`OFS_STATUS, 1, "low flag only");
      chk("irq masked", 0, {31'h0, irq});
      wr(`OFS_MASK, 3);
      n = 0;
      while (irq !== 1'b1 && n < 5) begin
         @(posedge pclk);
         n++;
      end
      chk("irq unmasked", 1, {31'h0, irq});
      if (irq !== 1'b1)
         finish_test;
      rdchk(`OFS_STATUS, 1, "flag kept");
      wr(`OFS_STATUS, 1);
      @(posedge pclk);
      chk("irq cleared", 0, {31'h0, irq});
      rdchk(`OFS_STATUS, 0, "flag cleared");
      $display("done interrupt test");
   endtask : t_irq
   task automatic t_trig;
      wr(`OFS_CMP, 32'h10);
      rdchk(`OFS_CMP, 32'h10, "compare");
      wr(`OFS_TRIG, 32'h08);
      wr(`OFS_STATUS, 3);
      wr(`OFS_CTRL, 32'h29);
      trig_lvl <= 8'h01;
      repeat (40) @(posedge pclk);
      rdchk(`OFS_STATUS, 1, "compare flag");
      rdcnt;
      chk("stopped at compare", 32'h10, {16'h0, c});
      trig_lvl <= 8'h00;
      wr(`OFS_CTRL, 0);
      $display("done trigger test");
   endtask : t_trig
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, fall_run, lp_run} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      trig_lvl = 8'h00;
      failures = 0;
      compares = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_rate;
      t_burst(32'h0d, 1'b0, 16'h0, 32'h0008);
      t_burst(32'h09, 1'b1, 16'h0, 32'h0008);
      t_burst(32'h1e, 1'b0, 16'h0, 32'h0800);
      t_burst(32'h1d, 1'b0, 16'h0, 32'h0008);
      t_burst(32'h5b, 1'b1, 16'h0, 32'h0808);
      t_burst(32'h05, 1'b0, 16'hff18, 32'h0000);
      t_burst(32'h15, 1'b0, 16'h40fc, 32'h4044);
      t_power;
      t_irq;
      t_trig;
      finish_test;
   end
endmodule : multimode_up_timer_test
`default_nettype wire

// ---- timer_consts.svh ----
// Register offsets, field positions, reset values and counts of the up timer
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_CTRL      12'h000
`define OFS_CNT_LO    12'h004
`define OFS_CNT_HI    12'h008
`define OFS_CMP       12'h00c
`define OFS_STATUS    12'h010
`define OFS_MASK      12'h014
`define OFS_PWR       12'h018
`define OFS_CLKCFG    12'h01c
`define OFS_TRIG      12'h020

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CTRL_RUN_LOW      0
`define CTRL_RUN_HIGH     1
`define CTRL_COUNT_MODE   2
`define CTRL_MAIN_LSB     3
`define CTRL_SUB_LSB      5
`define CTRL_WIDTH        7
`define STS_LOW_OVF       0
`define STS_HIGH_OVF      1
`define STS_WIDTH         2
`define PWR_DISABLE       0
`define PWR_DOWN          1
`define PWR_WIDTH         2
`define CLK_SEL           0
`define CLK_DIV_LSB       1
`define CLK_WIDTH         3
`define TRIG_SEL_LSB      0
`define TRIG_EDGE_LSB     3
`define TRIG_WIDTH        5

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_CTRL      7'h00
`define RST_CNT       8'h00
`define RST_CMP       16'h0000
`define RST_STATUS    2'h0
`define RST_MASK      2'h0
`define RST_PWR       2'h0
`define RST_CLKCFG    3'h0
`define RST_TRIG      5'h00

// ---------------------------------------------------------------
// Counting limits
// ---------------------------------------------------------------
`define LOW5_MAX      5'h1f
`define BYTE_MAX      8'hff

`endif

// ---- timer_pkg.sv ----
// Types shared by the up timer and its edge detector
`default_nettype none
package timer_pkg;

   // Decoded operating mode, one-hot
   typedef enum logic [5:0] {
      MODE_13BIT   = 6'b000001,
      MODE_16BIT   = 6'b000010,
      MODE_TRIG    = 6'b000100,
      MODE_RELOAD  = 6'b001000,
      MODE_SPLIT   = 6'b010000,
      MODE_MEASURE = 6'b100000
   } mode_e;

   typedef struct packed {
      logic [1:0] sub_mode;
      logic [1:0] main_mode;
      logic       count_mode;
      logic       high_run_bit;
      logic       low_run_bit;
   } ctrl_s;

   typedef struct packed {
      logic [1:0] div;
      logic       low_power_sel;
   } clkcfg_s;

   typedef struct packed {
      logic [1:0] edge_sel;
      logic [2:0] source_sel;
   } trig_s;

   typedef struct packed {
      logic rise;
      logic fall;
   } edges_s;

endpackage : timer_pkg
`default_nettype wire
